/* tsc_ctrl_port.sv */
`timescale 1ns/1ns
// Function
// - command bytes eight bits, msb first
// - reply bits shift out on host clock
// - reply pin high impedance unless sending
// - chip select bounds and aborts transfers
// - pending interrupt drives request pin low
// - interrupt pin is open drain, wire-or
// - three interrupt events flagged in status
// - powersaved functions raise no interrupt
// - control bits five, six gate interrupts
// - logic input level readable in status
// - control bit seven enables audio switch
// - tone one register sets tone one
// - tone two register sets tone two
// - transmit tones limited to 208-3000 hz
// - received tones reported within 313-6000 hz
// - control bit four gates transmit sum
module tsc_ctrl_port (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic cmd_data,
	output logic reply_out,
	output logic reply_oe_n,
	output logic irq_out,
	output logic irq_oe_n,
	input wire logic logic_in,
	input wire logic gp_timer_evt,
	input wire logic notone_evt,
	input wire logic rx_meas_evt,
	input wire logic [15:0] rx_meas_freq,
	output logic [15:0] tone1_freq,
	output logic [15:0] tone2_freq,
	output logic tone1_on,
	output logic tone2_on,
	output logic [3:0] powersave,
	output logic tx_sw_en,
	output logic audio_sw_en
);
	tsc_ser_if ser (); // byte link to the shifter
	tsc_pkg::dec_state_type st_reg; // decoder state
	logic [7:0] addr_reg; // address of this frame
	logic byte_idx_reg; // byte index after the address
	logic [7:0] hi_reg; // held high byte of a tone word
	logic [7:0] ctrl_reg; // control byte
	logic [2:0] flag_reg; // sticky event flags
	logic [2:0] flag_set; // events this cycle
	logic [2:0] flag_clr_reg; // flags reported in last read
	logic [2:0] irq_en; // per flag enable
	logic [2:0] lin_reg; // logic input synchroniser
	logic lin_f_reg; // accepted logic input level
	logic [15:0] rxf_reg; // last valid rx frequency
	logic [7:0] tx_byte_reg; // next reply byte
	logic reply_en_reg; // reply phase of the frame
	logic tone1_w; // tone 1 commit
	logic tone2_w; // tone 2 commit
	logic ctrl_w; // control commit
	logic gen_rst; // general reset command
	logic [15:0] tone_word; // assembled tone word
	// all checks run on the system clock, quiet while in reset
	default clocking cb_sys @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// inclusive range test used for both directions
	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// ======================================================
	// serial shifter
	// ======================================================
	tsc_ser_shift u_shift (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.sclk(sclk),
		.cs_n(cs_n),
		.cmd_data(cmd_data),
		.reply_out(reply_out),
		.reply_oe_n(reply_oe_n),
		.ser(ser.shift)
	);
	assign ser.tx_byte = tx_byte_reg;
	assign ser.reply_en = reply_en_reg;

	// ======================================================
	// command decoder
	// ======================================================
	assign tone_word = {hi_reg, ser.rx_byte};
	assign ctrl_w = ser.byte_valid && st_reg == tsc_pkg::DEC_WRITE
		&& addr_reg == tsc_pkg::CMD_CTRL;
	assign tone1_w = ser.byte_valid && st_reg == tsc_pkg::DEC_WRITE
		&& addr_reg == tsc_pkg::CMD_TONE1 && byte_idx_reg;
	assign tone2_w = ser.byte_valid && st_reg == tsc_pkg::DEC_WRITE
		&& addr_reg == tsc_pkg::CMD_TONE2 && byte_idx_reg;
	assign gen_rst = ser.byte_valid && st_reg == tsc_pkg::DEC_ADDR
		&& ser.rx_byte == tsc_pkg::CMD_RESET;

	// frame state: address byte first, then data bytes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= tsc_pkg::DEC_ADDR;
			addr_reg <= 8'h00;
			byte_idx_reg <= 1'b0;
			hi_reg <= 8'h00;
		end else if (ser.frame_start) begin
			// each new frame restarts decoding
			st_reg <= tsc_pkg::DEC_ADDR;
			byte_idx_reg <= 1'b0;
		end else if (ser.byte_valid) begin
			unique case (st_reg)
				tsc_pkg::DEC_ADDR: begin
					addr_reg <= ser.rx_byte;
					byte_idx_reg <= 1'b0;
					unique case (ser.rx_byte)
						tsc_pkg::CMD_CTRL,
						tsc_pkg::CMD_TONE1,
						tsc_pkg::CMD_TONE2: st_reg <= tsc_pkg::DEC_WRITE;
						tsc_pkg::CMD_STATUS,
						tsc_pkg::CMD_RXFREQ: st_reg <= tsc_pkg::DEC_READ;
						default: st_reg <= tsc_pkg::DEC_IGNORE;
					endcase
				end
				tsc_pkg::DEC_WRITE: begin
					hi_reg <= ser.rx_byte;
					byte_idx_reg <= 1'b1;
					// extra bytes after a full write are ignored
					if (addr_reg == tsc_pkg::CMD_CTRL || byte_idx_reg) begin
						st_reg <= tsc_pkg::DEC_IGNORE;
					end
				end
				tsc_pkg::DEC_READ: begin
					byte_idx_reg <= 1'b1;
					if (addr_reg == tsc_pkg::CMD_STATUS || byte_idx_reg) begin
						st_reg <= tsc_pkg::DEC_IGNORE;
					end
				end
				tsc_pkg::DEC_IGNORE: begin
					st_reg <= tsc_pkg::DEC_IGNORE;
				end
			endcase
		end
	end

	// ======================================================
	// reply byte selection
	// ======================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_byte_reg <= 8'h00;
			reply_en_reg <= 1'b0;
			flag_clr_reg <= 3'h0;
		end else begin
			flag_clr_reg <= 3'h0;
			if (ser.frame_start) begin
				reply_en_reg <= 1'b0;
			end else if (ser.byte_valid && st_reg == tsc_pkg::DEC_ADDR) begin
				reply_en_reg <= 1'b0;
				if (ser.rx_byte == tsc_pkg::CMD_STATUS) begin
					tx_byte_reg <= {4'h0, lin_f_reg, flag_reg};
					flag_clr_reg <= flag_reg;
					reply_en_reg <= 1'b1;
				end else if (ser.rx_byte == tsc_pkg::CMD_RXFREQ) begin
					tx_byte_reg <= rxf_reg[15:8];
					reply_en_reg <= 1'b1;
				end
			end else if (ser.byte_valid && st_reg == tsc_pkg::DEC_READ) begin
				// the low half follows the high half of rx frequency
				tx_byte_reg <= rxf_reg[7:0];
				reply_en_reg <= addr_reg == tsc_pkg::CMD_RXFREQ && !byte_idx_reg;
			end else if (ser.byte_valid) begin
				reply_en_reg <= 1'b0;
			end
		end
	end

	// ======================================================
	// control and tone registers
	// ======================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= tsc_pkg::CTRL_RESET_VAL;
		end else if (gen_rst) begin
			ctrl_reg <= tsc_pkg::CTRL_RESET_VAL;
		end else if (ctrl_w) begin
			ctrl_reg <= ser.rx_byte;
		end
	end

	// tone words out of range mean no tone
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tone1_freq <= tsc_pkg::TONE_RESET_VAL;
			tone2_freq <= tsc_pkg::TONE_RESET_VAL;
			tone1_on <= 1'b0;
			tone2_on <= 1'b0;
		end else if (gen_rst) begin
			tone1_freq <= tsc_pkg::TONE_RESET_VAL;
			tone2_freq <= tsc_pkg::TONE_RESET_VAL;
			tone1_on <= 1'b0;
			tone2_on <= 1'b0;
		end else begin
			if (tone1_w) begin
				tone1_freq <= tone_word;
				tone1_on <= in_range(tone_word, tsc_pkg::TX_FMIN,
					tsc_pkg::TX_FMAX);
			end
			if (tone2_w) begin
				tone2_freq <= tone_word;
				tone2_on <= in_range(tone_word, tsc_pkg::TX_FMIN,
					tsc_pkg::TX_FMAX);
			end
		end
	end

	// control bits reach pins through their own flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			powersave <= tsc_pkg::CTRL_RESET_VAL[3:0];
			tx_sw_en <= 1'b0;
			audio_sw_en <= 1'b0;
		end else begin
			powersave <= ctrl_reg[3:0];
			tx_sw_en <= ctrl_reg[tsc_pkg::CTRL_TX_SW];
			audio_sw_en <= ctrl_reg[tsc_pkg::CTRL_AUDIO_SW];
		end
	end

	// ======================================================
	// received frequency capture
	// ======================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rxf_reg <= 16'h0000;
		end else if (rx_meas_evt && !ctrl_reg[tsc_pkg::CTRL_PS_RX]
			&& in_range(rx_meas_freq, tsc_pkg::RX_FMIN, tsc_pkg::RX_FMAX)) begin
			rxf_reg <= rx_meas_freq;
		end
	end

	// ======================================================
	// events, flags and interrupt pin
	// ======================================================
	// timers and decoder asleep raise nothing
	assign flag_set[tsc_pkg::ST_GP] = gp_timer_evt
		&& !ctrl_reg[tsc_pkg::CTRL_PS_TIMER];
	assign flag_set[tsc_pkg::ST_NOTONE] = notone_evt
		&& !ctrl_reg[tsc_pkg::CTRL_PS_TIMER];
	assign flag_set[tsc_pkg::ST_RXMEAS] = rx_meas_evt
		&& !ctrl_reg[tsc_pkg::CTRL_PS_RX]
		&& in_range(rx_meas_freq, tsc_pkg::RX_FMIN, tsc_pkg::RX_FMAX);
	assign irq_en = {ctrl_reg[tsc_pkg::CTRL_IEN_RX],
		{2{ctrl_reg[tsc_pkg::CTRL_IEN_TIMER]}}};

	// set wins over the clear of a status read
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flag_reg <= 3'h0;
		end else begin
			flag_reg <= (flag_reg & ~flag_clr_reg) | flag_set;
		end
	end

	// open drain: output low, enable low pulls the line
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq_out <= 1'b0;
			irq_oe_n <= 1'b1;
		end else begin
			irq_out <= 1'b0;
			irq_oe_n <= !(|(flag_reg & irq_en));
		end
	end

	// logic input synchroniser, read live in status
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lin_reg <= 3'h0;
			lin_f_reg <= 1'b0;
		end else begin
			lin_reg <= {lin_reg[1:0], logic_in};
			if (lin_reg[1] == lin_reg[2]) begin
				lin_f_reg <= lin_reg[2];
			end
		end
	end

	// ======================================================
	// checks
	// ======================================================
	sequence s_timer_evt_awake;
		gp_timer_evt && !ctrl_reg[tsc_pkg::CTRL_PS_TIMER];
	endsequence
	sequence s_flag_then_irq;
		flag_reg[tsc_pkg::ST_GP] ##1 !irq_oe_n;
	endsequence
	a_event_flags: assert property (
		s_timer_evt_awake |=> flag_reg[tsc_pkg::ST_GP])
		else $error("event lost");
	a_powersave_mute: assert property (
		ctrl_reg[tsc_pkg::CTRL_PS_TIMER] && !flag_reg[tsc_pkg::ST_GP]
		&& !flag_clr_reg[0] |=> !flag_reg[tsc_pkg::ST_GP])
		else $error("asleep timer flagged");
	a_irq_enabled: assert property (
		s_timer_evt_awake ##1 ctrl_reg[tsc_pkg::CTRL_IEN_TIMER]
		|-> s_flag_then_irq)
		else $error("irq not raised");
	a_irq_masked: assert property (
		!(|(flag_reg & irq_en)) |=> irq_oe_n)
		else $error("masked irq driven");
	a_irq_open_drain: assert property (!irq_oe_n |-> !irq_out)
		else $error("irq driven high");
	a_irq_release: assert property (
		flag_clr_reg != 3'h0 && flag_set == 3'h0
		|=> (flag_reg & $past(flag_clr_reg)) == 3'h0)
		else $error("read did not clear");
	a_audio_switch: assert property (
		ctrl_w |=> ##1 audio_sw_en == $past(ser.rx_byte[7], 2))
		else $error("audio sw");
	a_tx_switch: assert property (
		ctrl_w |=> ##1 tx_sw_en == $past(ser.rx_byte[4], 2))
		else $error("tx sw");
	a_tone1_write: assert property (
		tone1_w |=> tone1_freq == $past(tone_word))
		else $error("tone 1 write");
	a_tone2_write: assert property (
		tone2_w |=> tone2_freq == $past(tone_word))
		else $error("tone 2 write");
	a_tone_range: assert property (
		tone1_on |-> tone1_freq >= tsc_pkg::TX_FMIN
		&& tone1_freq <= tsc_pkg::TX_FMAX)
		else $error("tone 1 out of range");
	a_rx_range: assert property (
		rx_meas_evt && rx_meas_freq > tsc_pkg::RX_FMAX |=> $stable(rxf_reg))
		else $error("rx out of range kept");
	a_logic_live: assert property (
		lin_reg[2] == lin_reg[1] |=> lin_f_reg == $past(lin_reg[2]))
		else $error("logic input stale");
endmodule : tsc_ctrl_port

/* tsc_pkg.sv */
// ==========================================================
// shared constants of the tone signaling control port
// ==========================================================
package tsc_pkg;
	// ======================================================
	// serial framing
	// ======================================================
	localparam int BYTE_BITS = 8; // bits per command byte
	localparam logic [2:0] BIT_LAST = 3'h7; // last bit index
	// ======================================================
	// command addresses (first byte of a frame)
	// ======================================================
	localparam logic [7:0] CMD_RESET = 8'h01; // general reset
	localparam logic [7:0] CMD_CTRL = 8'h30; // control, 1 byte
	localparam logic [7:0] CMD_TONE1 = 8'h31; // tone 1, 2 bytes
	localparam logic [7:0] CMD_TONE2 = 8'h32; // tone 2, 2 bytes
	localparam logic [7:0] CMD_STATUS = 8'h40; // status, 1 byte
	localparam logic [7:0] CMD_RXFREQ = 8'h41; // rx freq, 2 bytes
	// ======================================================
	// control byte fields
	// ======================================================
	localparam int CTRL_PS_TONE1 = 0; // tone 1 powersave
	localparam int CTRL_PS_TONE2 = 1; // tone 2 powersave
	localparam int CTRL_PS_RX = 2; // decoder powersave
	localparam int CTRL_PS_TIMER = 3; // timers powersave
	localparam int CTRL_TX_SW = 4; // tx sum switch
	localparam int CTRL_IEN_TIMER = 5; // timer irq enable
	localparam int CTRL_IEN_RX = 6; // rx measure irq enable
	localparam int CTRL_AUDIO_SW = 7; // audio switch
	localparam logic [7:0] CTRL_RESET_VAL = 8'h0f; // all asleep
	// ======================================================
	// status byte fields
	// ======================================================
	localparam int ST_GP = 0; // general timer expired
	localparam int ST_NOTONE = 1; // no-tone timer expired
	localparam int ST_RXMEAS = 2; // rx measurement done
	localparam int ST_LOGIC = 3; // logic input level
	// ======================================================
	// frequency limits in hz
	// ======================================================
	localparam logic [15:0] TX_FMIN = 16'h00d0; // 208
	localparam logic [15:0] TX_FMAX = 16'h0bb8; // 3000
	localparam logic [15:0] RX_FMIN = 16'h0139; // 313
	localparam logic [15:0] RX_FMAX = 16'h1770; // 6000
	localparam logic [15:0] TONE_RESET_VAL = 16'h0000; // notone
	// command decoder states
	typedef enum logic [1:0] {
		DEC_ADDR = 2'b00,
		DEC_WRITE = 2'b01,
		DEC_READ = 2'b10,
		DEC_IGNORE = 2'b11
	} dec_state_type;
endpackage : tsc_pkg

/* tsc_ser_if.sv */
`timescale 1ns/1ns
// ==========================================================
// byte level link between shifter and command decoder
// ==========================================================
interface tsc_ser_if;
	logic frame_start; // pulse: chip select went active
	logic byte_valid; // pulse: a full byte arrived
	logic [7:0] rx_byte; // received byte, msb first
	logic [7:0] tx_byte; // next reply byte
	logic reply_en; // reply pin may be driven
	modport shift (output frame_start, output byte_valid,
		output rx_byte, input tx_byte, input reply_en);
	modport dec (input frame_start, input byte_valid,
		input rx_byte, output tx_byte, output reply_en);
endinterface : tsc_ser_if

/* tsc_ser_shift.sv */
`timescale 1ns/1ns
// ==========================================================
// serial bit shifter on the host clock edges
// ==========================================================
module tsc_ser_shift (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic cmd_data,
	output logic reply_out,
	output logic reply_oe_n,
	tsc_ser_if.shift ser
);
	// three stage synchronisers, stage 1 feeds stage 2 only
	logic [2:0] m1_reg; // first stage: sclk, cs_n, data
	logic [2:0] m2_reg; // second stage
	logic [2:0] m3_reg; // third stage
	logic [2:0] f_reg; // accepted levels
	logic sclk_rise; // host clock rising edge
	logic sclk_fall; // host clock falling edge
	logic cs_act; // frame active
	logic [2:0] bit_cnt_reg; // bits of current byte
	logic [6:0] rx_sh_reg; // partial byte
	logic [7:0] tx_sh_reg; // reply shift
	logic fs_reg; // frame start pulse
	logic bv_reg; // byte valid pulse
	logic [7:0] rb_reg; // received byte
	// all checks run on the system clock, quiet while in reset
	default clocking cb_sys @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// ======================================================
	// pin synchronisers
	// ======================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			m1_reg <= 3'h3;
			m2_reg <= 3'h3;
			m3_reg <= 3'h3;
			f_reg <= 3'h3;
		end else begin
			m1_reg <= {cmd_data, cs_n, sclk};
			m2_reg <= m1_reg;
			m3_reg <= m2_reg;
			// a change counts once stages two and three agree
			for (int i = 0; i < 3; i++) begin
				if (m2_reg[i] == m3_reg[i]) begin
					f_reg[i] <= m3_reg[i];
				end
			end
		end
	end

	// edges from accepted levels only
	assign sclk_rise = (m2_reg[0] == m3_reg[0]) && m3_reg[0] && !f_reg[0];
	assign sclk_fall = (m2_reg[0] == m3_reg[0]) && !m3_reg[0] && f_reg[0];
	assign cs_act = !f_reg[1];

	// ======================================================
	// command byte shifting, msb first
	// ======================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_reg <= 3'h0;
			rx_sh_reg <= 7'h00;
			bv_reg <= 1'b0;
			rb_reg <= 8'h00;
		end else begin
			bv_reg <= 1'b0;
			if (!cs_act) begin
				// frame end or abort drops a partial byte
				bit_cnt_reg <= 3'h0;
			end else if (sclk_rise) begin
				rx_sh_reg <= {rx_sh_reg[5:0], f_reg[2]};
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == tsc_pkg::BIT_LAST) begin
					rb_reg <= {rx_sh_reg, f_reg[2]};
					bv_reg <= 1'b1;
				end
			end
		end
	end

	// frame start detection
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fs_reg <= 1'b0;
		end else begin
			fs_reg <= (m2_reg[1] == m3_reg[1]) && !m3_reg[1] && f_reg[1];
		end
	end

	// ======================================================
	// reply shifting on falling host clock edges
	// ======================================================
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_sh_reg <= 8'h00;
			reply_out <= 1'b0;
		end else if (cs_act && sclk_fall) begin
			// a byte boundary loads the next reply byte
			if (bit_cnt_reg == 3'h0) begin
				reply_out <= ser.tx_byte[7];
				tx_sh_reg <= {ser.tx_byte[6:0], 1'b0};
			end else begin
				reply_out <= tx_sh_reg[7];
				tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
			end
		end
	end

	// drive only inside a frame and only for reply bytes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reply_oe_n <= 1'b1;
		end else begin
			reply_oe_n <= !(cs_act && ser.reply_en);
		end
	end

	assign ser.frame_start = fs_reg;
	assign ser.byte_valid = bv_reg;
	assign ser.rx_byte = rb_reg;

	// ======================================================
	// checks
	// ======================================================
	a_reply_hiz_idle: assert property (!cs_act |=> reply_oe_n)
		else $error("reply driven outside frame");
	a_reply_edge_only: assert property (
		!sclk_fall |=> $stable(reply_out))
		else $error("reply moved off edge");
	a_frame_abort: assert property (!cs_act |=> bit_cnt_reg == 3'h0)
		else $error("bit count kept");
	a_msb_first: assert property (
		cs_act && sclk_rise && bit_cnt_reg == 3'h7
		|=> bv_reg && rb_reg[0] == $past(f_reg[2]))
		else $error("last bit not lsb");
endmodule : tsc_ser_shift

/* tsc_host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// host side of the serial link: frames, bytes, reply capture
// ==========================================================
module tsc_host_model (
	input wire logic sys_clk,
	input wire logic reply_out,
	output logic sclk,
	output logic cs_n,
	output logic cmd_data
);
	// clock idles high and stands still outside frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		cmd_data = 1'b0;
	end
	// half of the 80 ns serial period, in system cycles
	task half;
		repeat (10) @(posedge sys_clk);
	endtask : half
	// open a frame; select gives the start boundary
	task open;
		cs_n <= 1'b0;
		half();
	endtask : open
	// close; released data line shows the inverse level
	task close;
		cs_n <= 1'b1;
		cmd_data <= ~cmd_data;
		half();
	endtask : close
	// n bits, msb first; data changes on the falling edge
	task send(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sclk <= 1'b0;
			cmd_data <= tx[i];
			half();
			rx[i] = reply_out; // sampled just before the rise
			sclk <= 1'b1;
			half();
		end
	endtask : send
endmodule : tsc_host_model

/* test_tsc_ctrl_port.sv */
`timescale 1ns/1ns
// ==========================================================
// self-checking bench of the control port
// ==========================================================
module test_tsc_ctrl_port;
	logic sys_clk, rstn, sclk, cs_n, cmd_data, reply_out, reply_oe_n;
	logic irq_out, irq_oe_n, logic_in, gp_timer_evt, notone_evt;
	logic rx_meas_evt, tone1_on, tone2_on, tx_sw_en, audio_sw_en;
	logic [15:0] rx_meas_freq, tone1_freq, tone2_freq, q;
	logic [3:0] powersave;
	logic reply_line; // reply pin as the host sees it
	int failures = 0; // mismatches seen
	int compares = 0; // comparisons made
	tsc_ctrl_port i_tsc_ctrl_port (.sys_clk(sys_clk), .rstn(rstn),
		.sclk(sclk), .cs_n(cs_n), .cmd_data(cmd_data),
		.reply_out(reply_out), .reply_oe_n(reply_oe_n),
		.irq_out(irq_out), .irq_oe_n(irq_oe_n), .logic_in(logic_in),
		.gp_timer_evt(gp_timer_evt), .notone_evt(notone_evt),
		.rx_meas_evt(rx_meas_evt), .rx_meas_freq(rx_meas_freq),
		.tone1_freq(tone1_freq), .tone2_freq(tone2_freq),
		.tone1_on(tone1_on), .tone2_on(tone2_on),
		.powersave(powersave), .tx_sw_en(tx_sw_en),
		.audio_sw_en(audio_sw_en));
	tsc_host_model u_host (.sys_clk(sys_clk), .reply_out(reply_line),
		.sclk(sclk), .cs_n(cs_n), .cmd_data(cmd_data));
	// a released reply pin reads inverted, so late drive shows up
	assign reply_line = reply_oe_n ? ~reply_out : reply_out;
	// 4 ns system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ======================================================
	// helpers
	// ======================================================
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task results;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	// one frame: address then n data bytes, high byte first
	task frame(input logic [7:0] a, input logic [15:0] d, input int n);
		logic [7:0] r;
		u_host.open();
		u_host.send(a, 8, r);
		q = 16'h0000;
		for (int b = n - 1; b >= 0; b--) begin
			u_host.send(d[8*b +: 8], 8, r);
			q[8*b +: 8] = r;
		end
		u_host.close();
	endtask : frame
	// one-cycle event pulse
	task pulse(input int k, input logic [15:0] f);
		rx_meas_freq <= f;
		gp_timer_evt <= (k == 0);
		notone_evt <= (k == 1);
		rx_meas_evt <= (k == 2);
		@(posedge sys_clk);
		{gp_timer_evt, notone_evt, rx_meas_evt} <= 3'h0;
		repeat (4) @(posedge sys_clk);
	endtask : pulse
	// bounded wait for the request pin to pull low
	task wait_irq;
		int c;
		c = 0;
		while (irq_oe_n !== 1'b0) begin
			@(posedge sys_clk);
			if (++c > 20) begin
				chk(16'h0001, 16'h0000);
				results();
			end
		end
	endtask : wait_irq
	function logic [15:0] pins;
		return {8'h00, reply_oe_n, irq_oe_n, tx_sw_en, audio_sw_en,
			powersave};
	endfunction : pins
	// ======================================================
	// scenarios
	// ======================================================
	task t_reset;
		chk(pins(), 16'h00cf);
		chk(tone1_freq, 16'h0000);
		chk({15'h0000, irq_out}, 16'h0000);
		$display("t_reset done");
	endtask : t_reset
	task t_ctrl;
		frame(tsc_pkg::CMD_CTRL, 16'h00d0, 1);
		chk(pins(), 16'h00f0);
		$display("t_ctrl done");
	endtask : t_ctrl
	task t_tone;
		frame(tsc_pkg::CMD_TONE1, 16'h0bb8, 2);
		frame(tsc_pkg::CMD_TONE2, 16'h0bb9, 2);
		chk(tone1_freq, 16'h0bb8);
		chk(tone2_freq, 16'h0bb9);
		chk({14'h0000, tone1_on, tone2_on}, 16'h0002);
		frame(tsc_pkg::CMD_TONE1, 16'h00cf, 2);
		frame(tsc_pkg::CMD_TONE2, 16'h00d0, 2);
		chk({14'h0000, tone1_on, tone2_on}, 16'h0001);
		$display("t_tone done");
	endtask : t_tone
	task t_irq;
		logic_in <= 1'b1;
		pulse(0, 16'h0000);
		pulse(1, 16'h0000);
		chk({15'h0000, irq_oe_n}, 16'h0001);
		pulse(2, 16'h1770);
		wait_irq();
		chk({15'h0000, irq_out}, 16'h0000);
		frame(tsc_pkg::CMD_STATUS, 16'h0000, 1);
		chk(q, 16'h000f);
		chk({14'h0000, reply_oe_n, irq_oe_n}, 16'h0003);
		frame(tsc_pkg::CMD_RXFREQ, 16'h0000, 2);
		chk(q, 16'h1770);
		$display("t_irq done");
	endtask : t_irq
	task t_psave;
		logic_in <= 1'b0;
		frame(tsc_pkg::CMD_CTRL, 16'h006c, 1);
		pulse(0, 16'h0000);
		pulse(1, 16'h0000);
		pulse(2, 16'h0200);
		chk({15'h0000, irq_oe_n}, 16'h0001);
		frame(tsc_pkg::CMD_CTRL, 16'h0040, 1);
		pulse(2, 16'h1771);
		chk({15'h0000, irq_oe_n}, 16'h0001);
		frame(tsc_pkg::CMD_STATUS, 16'h0000, 1);
		chk(q, 16'h0000);
		$display("t_psave done");
	endtask : t_psave
	task t_abort;
		logic [7:0] r;
		u_host.open();
		u_host.send(tsc_pkg::CMD_CTRL, 8, r);
		u_host.send(8'hff, 4, r);
		u_host.close();
		chk(pins(), 16'h00c0);
		// a kept bit count would misalign this next frame
		frame(tsc_pkg::CMD_CTRL, 16'h0090, 1);
		chk(pins(), 16'h00f0);
		$display("t_abort done");
	endtask : t_abort
	// timer events with their enable set pull the request line
	task t_timer;
		frame(tsc_pkg::CMD_CTRL, 16'h0020, 1);
		pulse(0, 16'h0000);
		pulse(1, 16'h0000);
		wait_irq();
		frame(tsc_pkg::CMD_STATUS, 16'h0000, 1);
		chk(q, 16'h0003);
		chk({15'h0000, irq_oe_n}, 16'h0001);
		$display("t_timer done");
	endtask : t_timer
	// general reset command puts control and tones back
	task t_greset;
		frame(tsc_pkg::CMD_RESET, 16'h0000, 0);
		chk(pins(), 16'h00cf);
		chk(tone2_freq, 16'h0000);
		$display("t_greset done");
	endtask : t_greset
	// ======================================================
	// main sequence
	// ======================================================
	initial begin
		rstn = 1'b0;
		{logic_in, gp_timer_evt, notone_evt, rx_meas_evt} = 4'h0;
		rx_meas_freq = 16'h0000;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_ctrl();
		t_tone();
		t_irq();
		t_psave();
		t_abort();
		t_timer();
		t_greset();
		results();
	end
endmodule : test_tsc_ctrl_port
